// >>> hw/pwb_pkg.sv
package pwb_pkg;

    // Register offsets on the XDATA bus (block 0)
    localparam logic [15:0] XA_CNT_START  = 16'hF903;
    localparam logic [15:0] XA_INT_SEL0   = 16'hF908;
    localparam logic [15:0] XA_INT_SEL1   = 16'hF909;
    localparam logic [15:0] XA_INT_EF     = 16'hF90A;
    localparam logic [15:0] XA_ACC_CLR    = 16'hF90B;
    localparam logic [15:0] XA_WR_STS     = 16'hF90C;
    localparam logic [15:0] XA_CNT_LO     = 16'hF910;
    localparam logic [15:0] XA_CNT_HI     = 16'hF911;
    localparam logic [15:0] XA_LOWB_LO    = 16'hF91A;
    localparam logic [15:0] XA_LOWB_HI    = 16'hF91B;
    localparam logic [15:0] XA_UPB_LO     = 16'hF91C;
    localparam logic [15:0] XA_UPB_HI     = 16'hF91D;

    // SFR-bus aliases, write only
    localparam logic [7:0]  SA_LOWB       = 8'h62;
    localparam logic [7:0]  SA_UPB        = 8'h63;

    // Field positions
    localparam int          IEN1_BIT      = 5;
    localparam int          IEN0_BIT      = 4;
    localparam int          CLR_CPU_BIT   = 7;
    localparam int          CLR_SEC_BIT   = 6;
    localparam int          PEND_START    = 2;
    localparam int          PEND_SFR      = 1;
    localparam int          PEND_XDATA    = 0;

    // Fixed low bits of the compare values and reset values
    localparam logic [2:0]  LOWB_FIX      = 3'h0;
    localparam logic [2:0]  UPB_FIX       = 3'h7;
    localparam logic [7:0]  REG_RST       = 8'h00;

    // Write completion time: CPU clocks then PWM count cycles
    localparam logic [2:0]  WR_CPU_CYC    = 3'h6;
    localparam logic [4:0]  WR_PWM_CYC    = 5'h18;
    localparam int          DIV_W         = 4;

    // Host registers on AHB-Lite (byte addresses)
    localparam logic [4:0]  HA_ADDR       = 5'h00;
    localparam logic [4:0]  HA_DATA       = 5'h04;
    localparam logic [4:0]  HA_CTRL       = 5'h08;
    localparam logic [4:0]  HA_RDATA      = 5'h0C;
    localparam logic [4:0]  HA_ISTAT      = 5'h10;
    localparam logic [4:0]  HA_IMASK      = 5'h14;

    // Host command kinds
    localparam logic [1:0]  K_XRD         = 2'h0;
    localparam logic [1:0]  K_XWR         = 2'h1;
    localparam logic [1:0]  K_SWR         = 2'h2;

    typedef enum logic [2:0] {H_IDLE, H_POLL, H_CHK, H_WR, H_RD, H_RDW} pwb_hst_state_t;

    typedef struct packed {
        logic [6:0]       sel0;
        logic [6:0]       sel1;
        logic [1:0]       ien;
        logic [1:0]       iflg;
        logic [3:0]       start;
        logic [15:0]      cnt;
        logic [15:3]      lowb;
        logic [15:3]      upb;
        logic [7:0]       tmp;
        logic [7:0]       cpu_acc;
        logic [7:0]       sec_acc;
        logic [2:0][2:0]  pc;
        logic [2:0][4:0]  pt;
        logic [7:0]       rdata;
        logic [DIV_W-1:0] div;
    } pwb_dev_st_t;

    typedef struct packed {
        pwb_hst_state_t   st;
        logic [15:0]      caddr;
        logic [15:0]      cdata;
        logic [2:0]       ckind;
        logic [7:0]       rdat;
        logic [2:0]       ist;
        logic [2:0]       imask;
        logic [1:0]       irq_prev;
        logic             dp_wr;
        logic [4:0]       dp_addr;
        logic [31:0]      hrdata;
    } pwb_hst_st_t;

endpackage

// >>> hw/pwb_bus_if.sv
`timescale 1ns/1ps
interface pwb_bus_if;
    logic [15:0] x_addr;   // XDATA address
    logic        x_wr;     // XDATA write strobe
    logic        x_rd;     // XDATA read strobe
    logic [7:0]  x_wdata;  // XDATA write data
    logic [7:0]  x_rdata;  // XDATA read data, one cycle after x_rd
    logic [7:0]  s_addr;   // SFR address
    logic        s_wr;     // SFR write strobe
    logic        s_master; // 0 CPU, 1 secondary master
    logic [15:0] s_wdata;  // SFR one-word write data
    logic [1:0]  irq;      // Interrupt requests

    modport dev (
        input  x_addr, x_wr, x_rd, x_wdata, s_addr, s_wr, s_master, s_wdata,
        output x_rdata, irq
    );
    modport host (
        output x_addr, x_wr, x_rd, x_wdata, s_addr, s_wr, s_master, s_wdata,
        input  x_rdata, irq
    );
endinterface

// >>> hw/pwb_dev.sv
`timescale 1ns/1ps
module pwb_dev
    import pwb_pkg::*;
#(
    parameter logic [DIV_W-1:0] PWM_DIV   = 4'h4, // Clocks per PWM count cycle
    parameter int               BLOCK_IDX = 0     // Bit of the shared start register
) (
    input  wire logic        clk_sys,    // System clock
    input  wire logic        reset_n,    // Async reset, active low
    pwb_bus_if.dev           bus,        // Register buses
    input  wire logic [6:0]  evt_in,     // Internal PWM event pulses
    output logic      [15:0] count_val,  // Counter value
    output logic      [15:0] lower_cmp,  // Lower-bound compare
    output logic      [15:0] upper_cmp,  // Upper-bound compare
    output logic      [7:0]  cpu_acc,    // CPU SFR access count
    output logic      [7:0]  sec_acc,    // Secondary master SFR access count
    output logic             count_run   // Counter enabled
);

    pwb_dev_st_t q;
    pwb_dev_st_t n;
    logic [2:0]  pend;
    logic        tick;
    logic [1:0]  iset;
    logic [1:0]  iclr;
    logic [2:0]  launch;

    // PWM count tick; the divider runs free, so a pending span varies by up to one tick
    assign tick = (q.div == PWM_DIV - 1'b1);

    // A path is pending while either phase of its completion timer runs
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pend[i] = (q.pc[i] != 3'h0) || (q.pt[i] != 5'h00);
        end
    end

    // Any selected event sets its flag
    assign iset[0] = |(evt_in & q.sel0);
    assign iset[1] = |(evt_in & q.sel1);

    assign bus.irq[1]  = q.ien[1] & q.iflg[1];
    assign bus.irq[0]  = q.ien[0] & q.iflg[0];
    // Read data is registered and stands until the next read strobe
    assign bus.x_rdata = q.rdata;

    assign count_val = q.cnt;
    assign lower_cmp = {q.lowb, LOWB_FIX};
    assign upper_cmp = {q.upb, UPB_FIX};
    assign cpu_acc   = q.cpu_acc;
    assign sec_acc   = q.sec_acc;
    // Only this block's bit of the shared start register runs the counter
    assign count_run = q.start[BLOCK_IDX];

    always_comb begin
        n      = q;
        iclr   = 2'h0;
        launch = 3'h0;

        // The count advances once per tick while started and wraps at the top
        n.div = tick ? '0 : q.div + 1'b1;
        if (tick && q.start[BLOCK_IDX]) begin
            n.cnt = q.cnt + 16'h0001;
        end

        // Completion timers: CPU clocks first, then PWM count cycles
        for (int i = 0; i < 3; i++) begin
            if (q.pc[i] != 3'h0) begin
                n.pc[i] = q.pc[i] - 3'h1;
            end else if (tick && q.pt[i] != 5'h00) begin
                n.pt[i] = q.pt[i] - 5'h01;
            end
        end

        // XDATA writes; tracked writes are refused while their flag is up
        if (bus.x_wr) begin
            unique case (bus.x_addr)
                XA_CNT_START: begin
                    if (!pend[PEND_START]) begin
                        n.start           = bus.x_wdata[3:0];
                        launch[PEND_START] = 1'b1;
                    end
                end
                XA_INT_SEL0: n.sel0 = bus.x_wdata[6:0];
                XA_INT_SEL1: n.sel1 = bus.x_wdata[6:0];
                // Enables and flag clears share the XDATA pending guard
                XA_INT_EF: begin
                    if (!pend[PEND_XDATA]) begin
                        n.ien              = {bus.x_wdata[IEN1_BIT], bus.x_wdata[IEN0_BIT]};
                        iclr               = bus.x_wdata[1:0];
                        launch[PEND_XDATA] = 1'b1;
                    end
                end
                // Clear bits act only when written one and are never stored
                XA_ACC_CLR: begin
                    if (bus.x_wdata[CLR_CPU_BIT]) begin
                        n.cpu_acc = REG_RST;
                    end
                    if (bus.x_wdata[CLR_SEC_BIT]) begin
                        n.sec_acc = REG_RST;
                    end
                end
                // Low bytes are staged and land with the high byte
                XA_CNT_LO, XA_LOWB_LO, XA_UPB_LO: begin
                    if (!pend[PEND_XDATA]) begin
                        n.tmp = bus.x_wdata;
                    end
                end
                // The high byte commits both halves at once, so the count never tears
                XA_CNT_HI: begin
                    if (!pend[PEND_XDATA]) begin
                        n.cnt              = {bus.x_wdata, q.tmp};
                        launch[PEND_XDATA] = 1'b1;
                    end
                end
                // Staged low three bits are dropped; the fixed bits take their place
                XA_LOWB_HI: begin
                    if (!pend[PEND_XDATA]) begin
                        n.lowb             = {bus.x_wdata, q.tmp[7:3]};
                        launch[PEND_XDATA] = 1'b1;
                    end
                end
                XA_UPB_HI: begin
                    if (!pend[PEND_XDATA]) begin
                        n.upb              = {bus.x_wdata, q.tmp[7:3]};
                        launch[PEND_XDATA] = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // SFR aliases take the whole word at once
        // Refused alias writes neither update the compare nor count as accesses
        if (bus.s_wr && !pend[PEND_SFR] &&
            (bus.s_addr == SA_LOWB || bus.s_addr == SA_UPB)) begin
            if (bus.s_addr == SA_LOWB) begin
                n.lowb = bus.s_wdata[15:3];
            end else begin
                n.upb = bus.s_wdata[15:3];
            end
            launch[PEND_SFR] = 1'b1;
            // A clear in the same cycle still lets this access count
            if (bus.s_master) begin
                n.sec_acc = n.sec_acc + 8'h01;
            end else begin
                n.cpu_acc = n.cpu_acc + 8'h01;
            end
        end

        // A launch reloads both phases, so the span restarts from the full count
        for (int i = 0; i < 3; i++) begin
            if (launch[i]) begin
                n.pc[i] = WR_CPU_CYC;
                n.pt[i] = WR_PWM_CYC;
            end
        end

        // An event in the clearing cycle wins over the clear
        n.iflg = (q.iflg & ~iclr) | iset;

        // Write-only and unmapped locations read as zero
        if (bus.x_rd) begin
            unique case (bus.x_addr)
                XA_CNT_START: n.rdata = {4'h0, q.start};
                XA_INT_SEL0:  n.rdata = {1'b0, q.sel0};
                XA_INT_SEL1:  n.rdata = {1'b0, q.sel1};
                XA_INT_EF:    n.rdata = {2'h0, q.ien, 2'h0, q.iflg};
                XA_WR_STS:    n.rdata = {5'h00, pend};
                XA_CNT_LO:    n.rdata = q.cnt[7:0];
                XA_CNT_HI:    n.rdata = q.cnt[15:8];
                XA_LOWB_LO:   n.rdata = {q.lowb[7:3], LOWB_FIX};
                XA_LOWB_HI:   n.rdata = q.lowb[15:8];
                XA_UPB_LO:    n.rdata = {q.upb[7:3], UPB_FIX};
                XA_UPB_HI:    n.rdata = q.upb[15:8];
                default:      n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // Every stored field resets to zero; the fixed compare bits are not stored
            q <= '0;
        end else begin
            q <= n;
        end
    end

endmodule

// >>> hw/pwb_host.sv
`timescale 1ns/1ps
module pwb_host
    import pwb_pkg::*;
(
    input  wire logic        clk_sys,   // System clock
    input  wire logic        reset_n,   // Async reset, active low
    pwb_bus_if.host          bus,       // Register buses of the block
    input  wire logic        hsel,      // AHB-Lite select
    input  wire logic [31:0] haddr,     // AHB-Lite address
    input  wire logic [1:0]  htrans,    // AHB-Lite transfer type
    input  wire logic        hwrite,    // AHB-Lite write
    input  wire logic [2:0]  hsize,     // AHB-Lite size, word only
    input  wire logic [31:0] hwdata,    // AHB-Lite write data
    input  wire logic        hready,    // AHB-Lite bus ready
    output logic             hreadyout, // Always ready
    output logic      [31:0] hrdata,    // AHB-Lite read data
    output logic             hresp,     // Always OKAY
    output logic             irq        // Unmasked status pending
);

    pwb_hst_st_t q;
    pwb_hst_st_t n;
    logic        aphase;
    logic        busy;
    logic [2:0]  iset;
    logic        wait_bit;
    int unsigned widx;

    assign aphase    = hsel && htrans[1] && hready;
    assign busy      = (q.st != H_IDLE);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.hrdata;
    assign irq       = |(q.ist & q.imask);

    assign bus.x_addr   = (q.st == H_POLL) ? XA_WR_STS : q.caddr;
    assign bus.x_rd     = (q.st == H_POLL) || (q.st == H_RD);
    assign bus.x_wr     = (q.st == H_WR) && (q.ckind[1:0] == K_XWR);
    assign bus.x_wdata  = q.cdata[7:0];
    assign bus.s_addr   = q.caddr[7:0];
    assign bus.s_wr     = (q.st == H_WR) && (q.ckind[1:0] == K_SWR);
    assign bus.s_master = q.ckind[2];
    assign bus.s_wdata  = q.cdata;

    // Pending bit that guards the coming write
    always_comb begin
        if (q.ckind[1:0] == K_SWR) begin
            widx = PEND_SFR;
        end else if (q.caddr == XA_CNT_START) begin
            widx = PEND_START;
        end else begin
            widx = PEND_XDATA;
        end
    end
    assign wait_bit = bus.x_rdata[widx];

    always_comb begin
        n          = q;
        iset       = 3'h0;
        n.irq_prev = bus.irq;
        iset[1]    = bus.irq[0] & ~q.irq_prev[0];
        iset[2]    = bus.irq[1] & ~q.irq_prev[1];

        unique case (q.st)
            H_IDLE: ;
            H_POLL: n.st = H_CHK;
            // Status read returned this cycle; retry until clear
            H_CHK:  n.st = wait_bit ? H_POLL : H_WR;
            H_WR: begin
                n.st    = H_IDLE;
                iset[0] = 1'b1;
            end
            H_RD:   n.st = H_RDW;
            H_RDW: begin
                n.rdat  = bus.x_rdata;
                n.st    = H_IDLE;
                iset[0] = 1'b1;
            end
            default: n.st = H_IDLE;
        endcase

        n.dp_wr = aphase && hwrite;
        if (aphase) begin
            n.dp_addr = haddr[4:0];
        end

        if (q.dp_wr) begin
            unique case (q.dp_addr)
                HA_ADDR:  n.caddr = hwdata[15:0];
                HA_DATA:  n.cdata = hwdata[15:0];
                HA_IMASK: n.imask = hwdata[2:0];
                HA_CTRL: begin
                    // Orders given while busy are dropped
                    if (!busy && hwdata[0]) begin
                        n.ckind = hwdata[3:1];
                        n.st    = (hwdata[2:1] == K_XRD) ? H_RD : H_POLL;
                    end
                end
                default: ;
            endcase
        end

        if (aphase && !hwrite) begin
            unique case (haddr[4:0])
                HA_ADDR:  n.hrdata = {16'h0000, q.caddr};
                HA_DATA:  n.hrdata = {16'h0000, q.cdata};
                HA_CTRL:  n.hrdata = {31'h0, busy};
                HA_RDATA: n.hrdata = {24'h000000, q.rdat};
                HA_ISTAT: n.hrdata = {29'h0, q.ist};
                HA_IMASK: n.hrdata = {29'h0, q.imask};
                default:  n.hrdata = 32'h00000000;
            endcase
        end

        // Read clears status; a new event in that cycle survives
        if (aphase && !hwrite && haddr[4:0] == HA_ISTAT) begin
            n.ist = iset;
        end else begin
            n.ist = q.ist | iset;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q    <= '0;
            q.st <= H_IDLE;
        end else begin
            q <= n;
        end
    end

endmodule

// >>> dv/pwb_bus_sva.sv
`timescale 1ns/1ps
module pwb_bus_sva
    import pwb_pkg::*;
#(
    parameter int PWM_DIV = 4 // Clocks per PWM count cycle
) (
    input wire logic        clk_sys,  // System clock
    input wire logic        reset_n,  // Async reset, active low
    input wire logic [15:0] x_addr,   // XDATA address
    input wire logic        x_wr,     // XDATA write strobe
    input wire logic        x_rd,     // XDATA read strobe
    input wire logic [7:0]  x_wdata,  // XDATA write data
    input wire logic [7:0]  x_rdata,  // XDATA read data
    input wire logic [7:0]  s_addr,   // SFR address
    input wire logic        s_wr,     // SFR write strobe
    input wire logic        s_master, // SFR master
    input wire logic [15:0] s_wdata,  // SFR write data
    input wire logic [1:0]  irq       // Interrupt requests
);
    localparam int MIN_P = 6 + 23 * PWM_DIV + 1;
    localparam int MAX_P = 6 + 24 * PWM_DIV;

    logic [7:0] cx_q;
    logic [7:0] cs_q;
    logic [7:0] ct_q;
    wire logic  trk_x = x_wr && (x_addr == XA_INT_EF || x_addr == XA_CNT_HI
                        || x_addr == XA_LOWB_HI || x_addr == XA_UPB_HI);
    wire logic  trk_s = s_wr && (s_addr == SA_LOWB || s_addr == SA_UPB);
    wire logic  trk_t = x_wr && x_addr == XA_CNT_START;
    wire logic  sts_rd = x_rd && x_addr == XA_WR_STS;

    // Cycles since the last tracked write, saturating so old writes read as settled
    function automatic logic [7:0] step(input logic go, input logic [7:0] c);
        return go ? 8'h01 : ((c == 8'h00 || c == 8'hFF) ? c : c + 8'h01);
    endfunction

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cx_q <= 8'h00;
            cs_q <= 8'h00;
            ct_q <= 8'h00;
        end else begin
            cx_q <= step(trk_x, cx_q);
            cs_q <= step(trk_s, cs_q);
            ct_q <= step(trk_t, ct_q);
        end
    end

    // The span between the two bounds depends on the tick phase, so it is not judged
    property pend_p(logic [7:0] c, int b);
        @(posedge clk_sys) disable iff (!reset_n)
        sts_rd && !(c > MIN_P && c <= MAX_P)
        |=> x_rdata[b] == ($past(c) != 8'h00 && $past(c) <= MIN_P);
    endproperty

    irq_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        x_rd && x_addr == XA_INT_EF |=> (x_rdata[5:4] & x_rdata[1:0]) == $past(irq))
        else $error("request differs from enable and flag");
    acc_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        x_rd && x_addr == XA_ACC_CLR ##1 1'b1 |-> x_rdata == 8'h00)
        else $error("counter clear register reads nonzero");
    low_fix_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        x_rd && x_addr == XA_LOWB_LO |=> x_rdata[2:0] == LOWB_FIX)
        else $error("lower bound fixed bits wrong");
    up_fix_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        x_rd && x_addr == XA_UPB_LO |=> x_rdata[2:0] == UPB_FIX)
        else $error("upper bound fixed bits wrong");
    xdat_pend_a: assert property (pend_p(cx_q, PEND_XDATA))
        else $error("XDATA pending flag wrong");
    sfr_pend_a: assert property (pend_p(cs_q, PEND_SFR))
        else $error("SFR pending flag wrong");
    start_pend_a: assert property (pend_p(ct_q, PEND_START))
        else $error("start pending flag wrong");
    xdat_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        trk_x |-> cx_q == 8'h00 || cx_q > MIN_P)
        else $error("XDATA write while pending");
    sfr_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        trk_s |-> cs_q == 8'h00 || cs_q > MIN_P)
        else $error("SFR write while pending");
    start_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        trk_t |-> ct_q == 8'h00 || ct_q > MIN_P)
        else $error("start write while pending");

    irq_rise_c: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(irq[1]));
    sfr_wr_c: cover property (@(posedge clk_sys) disable iff (!reset_n) trk_s);
    start_wr_c: cover property (@(posedge clk_sys) disable iff (!reset_n) trk_t);
    sec_wr_c: cover property (@(posedge clk_sys) disable iff (!reset_n) trk_s && s_master);
    clr_wr_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
        x_wr && x_addr == XA_ACC_CLR && x_wdata[7]);
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import pwb_pkg::*;
;
    logic        clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, irq, count_run;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [6:0]  evt;
    logic [7:0]  cpu_acc, sec_acc;
    logic [15:0] count_val, lower_cmp, upper_cmp;
    logic [31:0] haddr, hwdata, hrdata, hrd;
    int          fails, n_checks;

    pwb_bus_if pwb_bus_if_inst ();
    pwb_dev #(.PWM_DIV(4'h4)) pwb_dev_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus(pwb_bus_if_inst), .evt_in(evt), .count_val(count_val), .lower_cmp(lower_cmp),
        .upper_cmp(upper_cmp), .cpu_acc(cpu_acc), .sec_acc(sec_acc), .count_run(count_run));
    pwb_host pwb_host_inst (.clk_sys(clk_sys), .reset_n(reset_n), .bus(pwb_bus_if_inst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .irq(irq));
    pwb_bus_sva #(.PWM_DIV(4)) pwb_bus_sva_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .x_addr(pwb_bus_if_inst.x_addr), .x_wr(pwb_bus_if_inst.x_wr),
        .x_rd(pwb_bus_if_inst.x_rd), .x_wdata(pwb_bus_if_inst.x_wdata),
        .x_rdata(pwb_bus_if_inst.x_rdata), .s_addr(pwb_bus_if_inst.s_addr),
        .s_wr(pwb_bus_if_inst.s_wr), .s_master(pwb_bus_if_inst.s_master),
        .s_wdata(pwb_bus_if_inst.s_wdata), .irq(pwb_bus_if_inst.irq));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hrd = hrdata;
        chk(16'(hresp), 16'h0000);
    endtask

    // Polls busy until the host is idle; only the watchdog ends a stuck wait
    task automatic cmd(input logic [1:0] k, input logic [15:0] a, input logic [15:0] d,
                       input logic m);
        ahb(1'b1, HA_ADDR, {16'h0, a});
        ahb(1'b1, HA_DATA, {16'h0, d});
        ahb(1'b1, HA_CTRL, {28'h0, m, k, 1'b1});
        repeat (2) @(posedge clk_sys);
        hrd = 32'h1;
        while (hrd[0] !== 1'b0) begin
            ahb(1'b0, HA_CTRL, 32'h0);
        end
        if (k == K_XRD) ahb(1'b0, HA_RDATA, 32'h0);
    endtask

    task automatic xw(input logic [15:0] a, input logic [7:0] d);
        cmd(K_XWR, a, {8'h0, d}, 1'b0);
    endtask

    task automatic xr(input logic [15:0] a, input logic [7:0] e);
        cmd(K_XRD, a, 16'h0, 1'b0);
        chk(hrd[15:0], {8'h0, e});
    endtask

    task automatic pulse(input logic [6:0] v);
        evt <= v;
        @(posedge clk_sys);
        evt <= 7'h0;
        @(posedge clk_sys);
    endtask

    task automatic t_reset();
        xr(XA_CNT_LO, 8'h00);
        xr(XA_CNT_HI, 8'h00);
        xr(XA_LOWB_LO, 8'h00);
        xr(XA_UPB_LO, 8'h07);
        xr(XA_ACC_CLR, 8'h00);
        xr(XA_WR_STS, 8'h00);
        chk(upper_cmp, 16'h0007);
        $display("test reset values done");
    endtask

    task automatic t_count();
        xw(XA_CNT_LO, 8'hA5);
        xw(XA_CNT_HI, 8'h3C);
        chk(count_val, 16'h3CA5);
        xr(XA_WR_STS, 8'h01);
        xw(XA_CNT_LO, 8'h5A);
        xr(XA_CNT_LO, 8'hA5);
        xr(XA_CNT_HI, 8'h3C);
        $display("test counter bytes done");
    endtask

    task automatic t_cmp();
        xw(XA_LOWB_LO, 8'hFF);
        xw(XA_LOWB_HI, 8'h12);
        chk(lower_cmp, 16'h12F8);
        xw(XA_UPB_LO, 8'h00);
        xw(XA_UPB_HI, 8'h34);
        chk(upper_cmp, 16'h3407);
        xr(XA_LOWB_LO, 8'hF8);
        xr(XA_UPB_HI, 8'h34);
        $display("test compare bytes done");
    endtask

    task automatic t_sfr();
        cmd(K_SWR, {8'h0, SA_LOWB}, 16'h5678, 1'b0);
        cmd(K_SWR, {8'h0, SA_UPB}, 16'hABC0, 1'b1);
        chk(lower_cmp, 16'h5678);
        chk(upper_cmp, 16'hABC7);
        xr(XA_LOWB_HI, 8'h56);
        chk(16'(cpu_acc), 16'h1);
        chk(16'(sec_acc), 16'h1);
        xw(XA_ACC_CLR, 8'h00);
        chk(16'(cpu_acc), 16'h1);
        xw(XA_ACC_CLR, 8'h80);
        chk(16'(cpu_acc), 16'h0);
        chk(16'(sec_acc), 16'h1);
        xw(XA_ACC_CLR, 8'h40);
        chk(16'(sec_acc), 16'h0);
        $display("test SFR aliases done");
    endtask

    task automatic t_sel();
        for (int i = 0; i < 7; i++) begin
            xw(XA_INT_SEL0, 8'h01 << i);
            xw(XA_INT_SEL1, 8'h01 << i);
            pulse(~(7'h01 << i));
            xr(XA_INT_EF, 8'h00);
            pulse(7'h01 << i);
            xr(XA_INT_EF, 8'h03);
            xw(XA_INT_EF, 8'h03);
        end
        xr(XA_INT_EF, 8'h00);
        $display("test event select done");
    endtask

    task automatic t_irq();
        ahb(1'b1, HA_IMASK, 32'h0);
        xw(XA_INT_EF, 8'h20);
        pulse(7'h40);
        chk(16'(pwb_bus_if_inst.irq), 16'h2);
        chk(16'(irq), 16'h0);
        xw(XA_INT_EF, 8'h20);
        chk(16'(pwb_bus_if_inst.irq), 16'h2);
        ahb(1'b1, HA_IMASK, 32'h4);
        @(posedge clk_sys);
        chk(16'(irq), 16'h1);
        ahb(1'b0, HA_ISTAT, 32'h0);
        chk(16'(hrd[2]), 16'h1);
        chk(16'(irq), 16'h0);
        xw(XA_INT_EF, 8'h22);
        chk(16'(pwb_bus_if_inst.irq), 16'h0);
        $display("test interrupt done");
    endtask

    task automatic t_start();
        xw(XA_CNT_START, 8'h01);
        chk(16'(count_run), 16'h1);
        cmd(K_XRD, XA_WR_STS, 16'h0, 1'b0);
        chk(16'(hrd[2]), 16'h1);
        xw(XA_CNT_START, 8'h00);
        chk(16'(count_run), 16'h0);
        $display("test counter start done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        evt = 7'h0;
        fails = 0;
        n_checks = 0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_count();
        t_cmp();
        t_sfr();
        t_sel();
        t_irq();
        t_start();
        results();
    end

    // The whole sequence needs a few thousand cycles; this allows a wide margin
    initial begin
        #400000;
        fails++;
        results();
    end
endmodule
